// >>> rtl/sto_pkg.sv
package sto_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_ST = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MK = 12'h00c;
  localparam logic [11:0] ADDR_FAULTS = 12'h010;

  localparam int CTRL_LATCH   = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_RESET   = 2;
  localparam int CTRL_RUN     = 3;

  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] APB_ERR_DATA   = 32'h0000_0000;

  // ----------------------------------------
  // Fault codes
  // ----------------------------------------
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_CH1_LOOP = 8'h48;
  localparam logic [7:0] CODE_STO      = 8'h4c;
  localparam logic [7:0] CODE_CH2_LOOP = 8'h4d;
  localparam logic [7:0] CODE_INT_LOOP = 8'h4e;

  localparam int NUM_EVT = 4;
  localparam int EVT_STO  = 0;
  localparam int EVT_CH1  = 1;
  localparam int EVT_CH2  = 2;
  localparam int EVT_INT  = 3;

  localparam int LOG_DEPTH = 8;
  localparam int LOG_AW    = 3;

  typedef enum logic [1:0] {
    STO_READY = 2'b00,
    STO_RUN   = 2'b01,
    STO_OFF   = 2'b11,
    STO_WAIT  = 2'b10
  } sto_run_e;

  typedef struct packed {
    logic       latch_sel;
    logic       restart_sel;
  } sto_cfg_s;

  typedef struct packed {
    logic       sto_alarm;
    logic       ch1_fault;
    logic       ch2_fault;
    logic       int_fault;
  } sto_alarm_s;

endpackage : sto_pkg

// >>> rtl/sto_log_mem.sv
module sto_log_mem (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     wr_en,
  input  wire logic [sto_pkg::LOG_AW-1:0] wr_addr,
  input  wire logic [7:0]               wr_data,
  input  wire logic [sto_pkg::LOG_AW-1:0] rd_addr,
  output logic      [7:0]               rd_data
);

  logic [7:0] mem [sto_pkg::LOG_DEPTH];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ----------------------------------------
  // Registered read
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : sto_log_mem

// >>> rtl/sto_supervisor.sv
module sto_supervisor (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        safety_channel_one,
  input  wire logic        safety_channel_two,
  input  wire logic        chan_one_check_bad,
  input  wire logic        chan_two_check_bad,
  input  wire logic        run_cmd,
  input  wire logic        reset_cmd,
  output logic             gate_path_one,
  output logic             gate_path_two,
  output logic             torque_on,
  output logic             keypad_sto_ind,
  output logic      [7:0]  fault_code,
  output logic             irq
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic       wr_acc;
  logic       addr_ok;
  logic [31:0] ctrl_reg;
  logic [3:0]  irq_st_reg;
  logic [3:0]  irq_mk_reg;
  logic        sw_reset;
  sto_pkg::sto_cfg_s   cfg;
  sto_pkg::sto_alarm_s alm_reg;
  sto_pkg::sto_run_e   st_reg;
  sto_pkg::sto_run_e   st_next;
  logic [7:0]  code_next;
  logic        any_reset;
  logic        ch_both;
  logic        ch_none;
  logic        run_prev_reg;
  logic        alarm_any;
  logic [3:0]  evt;
  logic [sto_pkg::LOG_AW-1:0] log_wp_reg;
  logic [7:0]  log_rd;
  logic [sto_pkg::LOG_AW-1:0] log_ra;

  assign wr_acc  = psel && penable && pwrite;
  assign pready  = 1'b1;

  always_comb begin
    unique case (paddr)
      sto_pkg::ADDR_CTRL, sto_pkg::ADDR_STATUS, sto_pkg::ADDR_IRQ_ST,
      sto_pkg::ADDR_IRQ_MK, sto_pkg::ADDR_FAULTS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;

  // Reset bit self clears; it is a command, not a setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= sto_pkg::CTRL_RESET_VAL;
    end else if (wr_acc && paddr == sto_pkg::ADDR_CTRL && pstrb[0]) begin
      ctrl_reg <= {24'h000000, 4'h0, pwdata[3:0]};
    end else begin
      ctrl_reg[sto_pkg::CTRL_RESET] <= 1'b0;
    end
  end

  assign cfg.latch_sel   = ctrl_reg[sto_pkg::CTRL_LATCH];
  assign cfg.restart_sel = ctrl_reg[sto_pkg::CTRL_RESTART];
  assign sw_reset        = ctrl_reg[sto_pkg::CTRL_RESET];
  assign any_reset       = reset_cmd || sw_reset;

  // ----------------------------------------
  // Channel decode
  // ----------------------------------------
  // channel decode
  assign ch_both = safety_channel_one && safety_channel_two;
  assign ch_none = !safety_channel_one && !safety_channel_two;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alm_reg <= '0;
    end else begin
      if (chan_one_check_bad && chan_two_check_bad) begin
        alm_reg.int_fault <= 1'b1;
      end else if (any_reset) begin
        alm_reg.int_fault <= 1'b0;
      end
      if (safety_channel_one && !safety_channel_two) begin
        alm_reg.ch2_fault <= 1'b1;
      end else if (any_reset) begin
        alm_reg.ch2_fault <= 1'b0;
      end
      if (!safety_channel_one && safety_channel_two) begin
        alm_reg.ch1_fault <= 1'b1;
      end else if (any_reset) begin
        alm_reg.ch1_fault <= 1'b0;
      end
      if (ch_none) begin
        alm_reg.sto_alarm <= 1'b1;
      end else if (any_reset || cfg.latch_sel) begin
        alm_reg.sto_alarm <= 1'b0;
      end
    end
  end

  assign alarm_any = alm_reg.sto_alarm || alm_reg.ch1_fault || alm_reg.ch2_fault ||
                     alm_reg.int_fault || !ch_both ||
                     (chan_one_check_bad && chan_two_check_bad);

  // ----------------------------------------
  // Run sequencing
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= run_cmd;
    end
  end

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      sto_pkg::STO_READY: if (alarm_any) st_next = sto_pkg::STO_OFF;
                          else if (run_cmd) st_next = sto_pkg::STO_RUN;
      sto_pkg::STO_RUN:   if (alarm_any) st_next = sto_pkg::STO_OFF;
                          else if (!run_cmd) st_next = sto_pkg::STO_READY;
      sto_pkg::STO_OFF:   if (!alarm_any) begin
                            if (run_cmd && cfg.restart_sel) st_next = sto_pkg::STO_RUN;
                            else st_next = sto_pkg::STO_WAIT;
                          end
      sto_pkg::STO_WAIT:  if (alarm_any) st_next = sto_pkg::STO_OFF;
                          else if (!run_cmd) st_next = sto_pkg::STO_READY;
                          else if (!run_prev_reg) st_next = sto_pkg::STO_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= sto_pkg::STO_READY;
    end else begin
      st_reg <= st_next;
    end
  end

  assign gate_path_one = safety_channel_one && (st_reg == sto_pkg::STO_RUN);
  assign gate_path_two = safety_channel_two && (st_reg == sto_pkg::STO_RUN);
  assign torque_on     = gate_path_one && gate_path_two;

  // ----------------------------------------
  // Fault code and indication
  // ----------------------------------------
  always_comb begin
    code_next = sto_pkg::CODE_NONE;
    if (alm_reg.int_fault) code_next = sto_pkg::CODE_INT_LOOP;
    else if (alm_reg.ch1_fault) code_next = sto_pkg::CODE_CH1_LOOP;
    else if (alm_reg.ch2_fault) code_next = sto_pkg::CODE_CH2_LOOP;
    else if (alm_reg.sto_alarm) code_next = sto_pkg::CODE_STO;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_code     <= sto_pkg::CODE_NONE;
      keypad_sto_ind <= 1'b0;
    end else begin
      fault_code     <= code_next;
      keypad_sto_ind <= alm_reg.sto_alarm;
    end
  end

  // Fault history, newest entry written at each new code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_wp_reg <= '0;
    end else if (code_next != fault_code && code_next != sto_pkg::CODE_NONE) begin
      log_wp_reg <= log_wp_reg + 1'b1;
    end
  end

  assign log_ra = paddr[sto_pkg::LOG_AW+1:2];

  sto_log_mem u_log (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (code_next != fault_code && code_next != sto_pkg::CODE_NONE),
    .wr_addr (log_wp_reg),
    .wr_data (code_next),
    .rd_addr (log_wp_reg - log_ra - 1'b1),
    .rd_data (log_rd)
  );

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign evt = {alm_reg.int_fault, alm_reg.ch2_fault, alm_reg.ch1_fault, alm_reg.sto_alarm};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg <= '0;
      irq_mk_reg <= '0;
    end else begin
      if (wr_acc && paddr == sto_pkg::ADDR_IRQ_MK) begin
        irq_mk_reg <= pwdata[3:0];
      end
      if (wr_acc && paddr == sto_pkg::ADDR_IRQ_ST) begin
        irq_st_reg <= (irq_st_reg & ~pwdata[3:0]) | evt;
      end else begin
        irq_st_reg <= irq_st_reg | evt;
      end
    end
  end

  assign irq = |(irq_st_reg & irq_mk_reg);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    unique case (paddr)
      sto_pkg::ADDR_CTRL:   prdata = {28'h0000000, ctrl_reg[3:0]};
      sto_pkg::ADDR_STATUS: prdata = {16'h0000, fault_code, 2'b00, st_reg, alm_reg};
      sto_pkg::ADDR_IRQ_ST: prdata = {28'h0000000, irq_st_reg};
      sto_pkg::ADDR_IRQ_MK: prdata = {28'h0000000, irq_mk_reg};
      sto_pkg::ADDR_FAULTS: prdata = {24'h000000, log_rd};
      default:              prdata = sto_pkg::APB_ERR_DATA;
    endcase
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // keypad and restart steps
  sequence both_open_s;
    ch_none;
  endsequence

  sequence sto_shown_s;
    alm_reg.sto_alarm ##1 keypad_sto_ind;
  endsequence

  sequence alarm_gone_s;
    st_reg == sto_pkg::STO_OFF && !alarm_any;
  endsequence

  both_off_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    both_open_s |=> !torque_on)
    else $error("torque while both channels off");
  alarm_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == sto_pkg::STO_RUN && alarm_any |=> st_reg == sto_pkg::STO_OFF)
    else $error("run kept under alarm");
  path_one_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
    !safety_channel_one |-> !gate_path_one)
    else $error("path one live");
  path_two_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
    !safety_channel_two |-> !gate_path_two)
    else $error("path two live");
  ch1_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
    !safety_channel_one && safety_channel_two |=> alm_reg.ch1_fault)
    else $error("ch1 fault missed");
  ch2_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
    safety_channel_one && !safety_channel_two |=> alm_reg.ch2_fault)
    else $error("ch2 fault missed");
  int_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
    chan_one_check_bad && chan_two_check_bad |=> alm_reg.int_fault)
    else $error("internal fault missed");
  ch1_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    alm_reg.ch1_fault && !any_reset |=> alm_reg.ch1_fault)
    else $error("ch1 fault dropped");
  ch2_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    alm_reg.ch2_fault && !any_reset |=> alm_reg.ch2_fault)
    else $error("ch2 fault dropped");
  int_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    alm_reg.int_fault && !any_reset |=> alm_reg.int_fault)
    else $error("internal fault dropped");
  sto_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    alm_reg.sto_alarm && !cfg.latch_sel && !any_reset |=> alm_reg.sto_alarm)
    else $error("sto dropped");
  sto_auto_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.latch_sel && !ch_none |=> !alm_reg.sto_alarm)
    else $error("sto not cleared");
  code_sto_a: assert property (@(posedge pclk) disable iff (!presetn)
    alm_reg == 4'b1000 |=> fault_code == sto_pkg::CODE_STO)
    else $error("wrong sto code");
  code_ch1_a: assert property (@(posedge pclk) disable iff (!presetn)
    !alm_reg.int_fault && alm_reg.ch1_fault |=> fault_code == sto_pkg::CODE_CH1_LOOP)
    else $error("wrong ch1 code");
  code_ch2_a: assert property (@(posedge pclk) disable iff (!presetn)
    !alm_reg.int_fault && !alm_reg.ch1_fault && alm_reg.ch2_fault |=> fault_code == sto_pkg::CODE_CH2_LOOP)
    else $error("wrong ch2 code");
  code_int_a: assert property (@(posedge pclk) disable iff (!presetn)
    alm_reg.int_fault |=> fault_code == sto_pkg::CODE_INT_LOOP)
    else $error("wrong internal code");
  keypad_show_a: assert property (@(posedge pclk) disable iff (!presetn)
    both_open_s |=> sto_shown_s)
    else $error("keypad indication missed");
  run_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == sto_pkg::STO_READY && !alarm_any && run_cmd |=> st_reg == sto_pkg::STO_RUN)
    else $error("run not followed");
  stop_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == sto_pkg::STO_RUN && !alarm_any && !run_cmd |=> st_reg == sto_pkg::STO_READY)
    else $error("stop not followed");
  resume_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_gone_s ##0 (run_cmd && cfg.restart_sel) |=> st_reg == sto_pkg::STO_RUN)
    else $error("no resume");
  fresh_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == sto_pkg::STO_OFF && !cfg.restart_sel |=> st_reg != sto_pkg::STO_RUN)
    else $error("restart");
  wait_fresh_a: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_gone_s ##0 (!cfg.restart_sel) |=> st_reg == sto_pkg::STO_WAIT)
    else $error("wait state missed");

endmodule : sto_supervisor

// >>> dv/sto_partner.sv
// ----------------------------------------
// Safety switch and run/stop source
// ----------------------------------------
module sto_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic switch_closed,
  input  wire logic cut_one,
  input  wire logic cut_two,
  input  wire logic diag_bad,
  input  wire logic run_hold,
  input  wire logic rst_push,
  output logic      safety_channel_one,
  output logic      safety_channel_two,
  output logic      chan_one_check_bad,
  output logic      chan_two_check_bad,
  output logic      run_cmd,
  output logic      reset_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Opening the switch de-energises both channels; a cut wire only its own
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Channels rest energised, so no false opening follows reset
      safety_channel_one <= 1'b1;
      safety_channel_two <= 1'b1;
      chan_one_check_bad <= 1'b0;
      chan_two_check_bad <= 1'b0;
      run_cmd            <= 1'b0;
      reset_cmd          <= 1'b0;
    end else begin
      safety_channel_one <= switch_closed & ~cut_one;
      safety_channel_two <= switch_closed & ~cut_two;
      chan_one_check_bad <= diag_bad;
      chan_two_check_bad <= diag_bad;
      run_cmd            <= run_hold;
      reset_cmd          <= rst_push;
    end
  end
endmodule : sto_partner

// >>> dv/safe_torque_off_supervisor_tb.sv
module safe_torque_off_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, er, ch1, ch2, cb1, cb2, run, rst;
  logic        g1, g2, torque_on, keypad_sto_ind, irq;
  logic [7:0]  fault_code;
  logic        est = 1'b1, cut1 = 1'b0, cut2 = 1'b0, bad = 1'b0, runh = 1'b0, rsth = 1'b0;
  int          err_count = 0, cmp_count = 0;

  always #4 pclk = ~pclk;

  sto_partner sto_partner_i (.pclk(pclk), .presetn(presetn), .switch_closed(est), .cut_one(cut1),
    .cut_two(cut2), .diag_bad(bad), .run_hold(runh), .rst_push(rsth), .safety_channel_one(ch1),
    .safety_channel_two(ch2), .chan_one_check_bad(cb1), .chan_two_check_bad(cb2), .run_cmd(run),
    .reset_cmd(rst));
  sto_supervisor sto_supervisor_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .safety_channel_one(ch1), .safety_channel_two(ch2), .chan_one_check_bad(cb1),
    .chan_two_check_bad(cb2), .run_cmd(run), .reset_cmd(rst), .gate_path_one(g1), .gate_path_two(g2),
    .torque_on(torque_on), .keypad_sto_ind(keypad_sto_ind), .fault_code(fault_code), .irq(irq));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle
  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task pulse_reset;
    @(posedge pclk) rsth <= 1'b1;
    @(posedge pclk) rsth <= 1'b0;
    settle(4);
  endtask : pulse_reset
  task set_run(input logic v);
    @(posedge pclk) runh <= v;
    settle(4);
  endtask : set_run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    apb(1'b0, sto_pkg::ADDR_CTRL, 32'h0000_0000);
    chk("ctrl reset", sto_pkg::CTRL_RESET_VAL, rd);
    apb(1'b0, 12'hffc, 32'h0000_0000);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", sto_pkg::APB_ERR_DATA, rd);
  endtask : t_regs
  task t_normal;
    apb(1'b1, sto_pkg::ADDR_CTRL, 32'h0000_0000);
    set_run(1'b1);
    chk("torque run", 32'h1, {31'h0, torque_on});
    set_run(1'b0);
    chk("torque stop", 32'h0, {31'h0, torque_on});
  endtask : t_normal
  // Latch setting 1 here: channel faults must hold anyway
  task t_single(input logic which);
    apb(1'b1, sto_pkg::ADDR_CTRL, 32'h0000_0001);
    set_run(1'b1);
    @(posedge pclk) begin
      cut1 <= which;
      cut2 <= !which;
    end
    settle(1);
    chk("cut path", 32'h0, {31'h0, which ? g1 : g2});
    chk("cut torque", 32'h0, {31'h0, torque_on});
    settle(4);
    chk("chan code", {24'h0, which ? sto_pkg::CODE_CH1_LOOP : sto_pkg::CODE_CH2_LOOP}, {24'h0, fault_code});
    @(posedge pclk) {cut1, cut2} <= 2'b00;
    settle(4);
    chk("chan latch", {24'h0, which ? sto_pkg::CODE_CH1_LOOP : sto_pkg::CODE_CH2_LOOP}, {24'h0, fault_code});
    pulse_reset();
    chk("chan clear", {24'h0, sto_pkg::CODE_NONE}, {24'h0, fault_code});
    set_run(1'b0);
  endtask : t_single
  task t_internal;
    @(posedge pclk) bad <= 1'b1;
    settle(4);
    chk("int code", {24'h0, sto_pkg::CODE_INT_LOOP}, {24'h0, fault_code});
    @(posedge pclk) bad <= 1'b0;
    settle(4);
    chk("int latch", {24'h0, sto_pkg::CODE_INT_LOOP}, {24'h0, fault_code});
    pulse_reset();
  endtask : t_internal
  task t_switch_open;
    apb(1'b1, sto_pkg::ADDR_CTRL, 32'h0000_0000);
    set_run(1'b1);
    @(posedge pclk) est <= 1'b0;
    settle(1);
    chk("open torque", 32'h0, {31'h0, torque_on});
    settle(4);
    chk("open keypad", 32'h1, {31'h0, keypad_sto_ind});
    chk("sto code", {24'h0, sto_pkg::CODE_STO}, {24'h0, fault_code});
    @(posedge pclk) est <= 1'b1;
    settle(4);
    chk("sto held", 32'h1, {31'h0, keypad_sto_ind});
    pulse_reset();
    chk("sto cleared", 32'h0, {31'h0, keypad_sto_ind});
    chk("no restart", 32'h0, {31'h0, torque_on});
    set_run(1'b0);
    set_run(1'b1);
    chk("fresh run", 32'h1, {31'h0, torque_on});
  endtask : t_switch_open
  task t_restart;
    apb(1'b1, sto_pkg::ADDR_CTRL, 32'h0000_0002);
    @(posedge pclk) est <= 1'b0;
    settle(4);
    @(posedge pclk) est <= 1'b1;
    settle(4);
    apb(1'b1, sto_pkg::ADDR_CTRL, 32'h0000_0006);
    settle(4);
    chk("resume", 32'h1, {31'h0, torque_on});
    apb(1'b1, sto_pkg::ADDR_CTRL, 32'h0000_0003);
    @(posedge pclk) est <= 1'b0;
    settle(4);
    @(posedge pclk) est <= 1'b1;
    settle(4);
    chk("auto clear", 32'h0, {31'h0, keypad_sto_ind});
    set_run(1'b0);
  endtask : t_restart
  task t_irq;
    apb(1'b1, sto_pkg::ADDR_IRQ_MK, 32'h0000_0001);
    apb(1'b1, sto_pkg::ADDR_IRQ_ST, 32'h0000_000f);
    apb(1'b0, sto_pkg::ADDR_IRQ_ST, 32'h0000_0000);
    chk("irq st clear", 32'h0, rd);
    chk("irq low", 32'h0, {31'h0, irq});
    @(posedge pclk) est <= 1'b0;
    settle(4);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, sto_pkg::ADDR_IRQ_ST, 32'h0000_0001);
    settle(2);
    chk("irq reset", 32'h1, {31'h0, irq});
    apb(1'b1, sto_pkg::ADDR_IRQ_MK, 32'h0000_0000);
    settle(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    @(posedge pclk) est <= 1'b1;
    settle(4);
    apb(1'b1, sto_pkg::ADDR_IRQ_ST, 32'h0000_000f);
    apb(1'b0, sto_pkg::ADDR_IRQ_ST, 32'h0000_0000);
    chk("irq st end", 32'h0, rd);
  endtask : t_irq

  // Limit sits far above the few hundred cycles the run needs
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
    t_regs();
    pulse_reset();
    t_normal();
    t_single(1'b1);
    t_single(1'b0);
    t_internal();
    t_switch_open();
    t_restart();
    t_irq();
    give_verdict();
  end
endmodule : safe_torque_off_supervisor_tb
